//--- inc/msb_pkg.sv
/*
 * Constants, register offsets and carrier types for the metering SFR bridge.
 * Assumes a single 100 MHz system clock and an 8-bit SFR bus.
 */
package msb_pkg;

  // Clock rates; the metering core runs on an enable derived from clk.
  localparam longint SYS_CLK_HZ  = 100_000_000;
  localparam longint MCLK_SRC_HZ = 4_096_000;
  localparam longint MCLK_DIV    = 5;
  localparam longint MCLK_HZ_X10 = (MCLK_SRC_HZ * 10) / MCLK_DIV;
  localparam int     MTICK_CYC   =
    int'((SYS_CLK_HZ * 10) / MCLK_HZ_X10);

  // Pointer SFR fields.
  localparam int PTR_DIR_BIT = 7;
  localparam int PTR_ADR_MSB = 6;

  // SFR addresses.
  localparam logic [7:0] SFR_PTR    = 8'h91;
  localparam logic [7:0] SFR_DAT_L  = 8'h92;
  localparam logic [7:0] SFR_DAT_M  = 8'h93;
  localparam logic [7:0] SFR_DAT_H  = 8'h94;
  localparam logic [7:0] SFR_VRMS_L = 8'hD1;
  localparam logic [7:0] SFR_VRMS_M = 8'hD2;
  localparam logic [7:0] SFR_VRMS_H = 8'hD3;
  localparam logic [7:0] SFR_IRMS_L = 8'hD4;
  localparam logic [7:0] SFR_IRMS_M = 8'hD5;
  localparam logic [7:0] SFR_IRMS_H = 8'hD6;
  localparam logic [7:0] SFR_IEN_L  = 8'hD9;
  localparam logic [7:0] SFR_IEN_M  = 8'hDA;
  localparam logic [7:0] SFR_IEN_H  = 8'hDB;
  localparam logic [7:0] SFR_IST_L  = 8'hDC;
  localparam logic [7:0] SFR_IST_M  = 8'hDD;
  localparam logic [7:0] SFR_IST_H  = 8'hDE;
  localparam logic [7:0] SFR_WAV1_L = 8'hE2;
  localparam logic [7:0] SFR_WAV1_M = 8'hE3;
  localparam logic [7:0] SFR_WAV1_H = 8'hE4;
  localparam logic [7:0] SFR_WAV2_L = 8'hE5;
  localparam logic [7:0] SFR_WAV2_M = 8'hE6;
  localparam logic [7:0] SFR_WAV2_H = 8'hE7;

  // Internal addresses whose read clears the accumulator or peak.
  localparam logic [6:0] IADR_RD_CLR_WH   = 7'h02;
  localparam logic [6:0] IADR_RD_CLR_VARH = 7'h05;
  localparam logic [6:0] IADR_RD_CLR_VAH  = 7'h08;
  localparam logic [6:0] IADR_RD_CLR_IPK  = 7'h18;
  localparam logic [6:0] IADR_RD_CLR_VPK  = 7'h1A;

  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [23:0] WORD_ZERO = 24'h00_0000;

  typedef enum logic [1:0] {
    MSB_IDLE = 2'b00,
    MSB_ISSUE = 2'b01,
    MSB_FETCH = 2'b10
  } msb_state_t;

  // One request from the bridge to the metering register file.
  typedef struct packed {
    logic        wr_stb;
    logic        rd_stb;
    logic        rd_clear;
    logic [6:0]  addr;
    logic [23:0] wdata;
  } msb_mreq_t;

  // Four direct 24-bit results presented by the metering core.
  typedef struct packed {
    logic [23:0] vrms;
    logic [23:0] irms;
    logic [23:0] wav1;
    logic [23:0] wav2;
  } msb_direct_t;

endpackage : msb_pkg

//--- rtl/msb_bridge.sv
/*
 * Metering SFR access bridge: direct result SFRs with high-byte latching,
 * interrupt enable/status bytes and the indirect pointer/data access path
 * into the metering register file.
 * Assumes the SFR bus is synchronous to clk and that the metering core
 * answers a read strobe with data valid by its next metering tick.
 */
// Behaviour
// - The pointer register holds the direction in bit 7 (1 write, 0 read) and the internal address in bits 6:0.
// - A pointer write with the direction set sends the three data bytes to the selected internal register.
// - For a one-byte internal register only the low data byte is sent and the other two are ignored.
// - A pointer write with the direction clear loads the selected internal register into the three data bytes.
// - A read of a one-byte internal register updates the low data byte and clears the middle and high bytes.
// - The metering side runs at 4.096 MHz divided by five, so every transfer is timed to its own tick.
// - Each interrupt byte is latched from the live value at the moment that byte is read.
// - Reading the high byte of a three-byte result captures all 24 bits.
// - Reading the low or middle byte before the high byte returns the previously captured sample.
// - The pointer sits at 0x91 and the low, middle and high data bytes at 0x92 to 0x94, all read/write.
// - Interrupt enable bytes sit at 0xD9 to 0xDB and status bytes at 0xDC to 0xDE, read/write.
// - Waveform sample one sits at 0xE2 to 0xE4 and sample two at 0xE5 to 0xE7, read-only.
// - Some internal addresses clear their accumulator when read, such as address 0x02.
module msb_bridge #(
  parameter int TICK_CYC = msb_pkg::MTICK_CYC
) (
  input  wire logic                 clk,           // System clock.
  input  wire logic                 rst,           // Async reset, high.
  input  wire logic [7:0]           sfr_addr,      // SFR address.
  input  wire logic                 sfr_wr,        // SFR write strobe.
  input  wire logic                 sfr_rd,        // SFR read strobe.
  input  wire logic [7:0]           sfr_wdata,     // SFR write data.
  output logic      [7:0]           sfr_rdata,     // SFR read data.
  output logic                      sfr_hit,       // Address was ours.
  input  wire msb_pkg::msb_direct_t direct_in,     // Live results.
  input  wire logic [23:0]          irq_event,     // Status set pulses.
  output logic      [23:0]          irq_enable,    // Enable bytes.
  output logic      [23:0]          irq_status,    // Sticky status.
  output msb_pkg::msb_mreq_t        mreq,          // Metering request.
  input  wire logic [23:0]          mreg_rdata,    // Metering read data.
  input  wire logic                 mreg_one_byte, // Selected reg 8-bit.
  output logic                      meter_tick,    // Metering enable.
  output logic                      xfer_busy      // Transfer pending.
);

  initial begin
    if (TICK_CYC < 2) begin
      $error("TICK_CYC must be at least 2");
    end
  end

  localparam int CW = $clog2(TICK_CYC + 1);

  function automatic logic [7:0] pick_byte(input logic [23:0] w,
                                           input logic [1:0] sel);
    logic [7:0] b;
    b = w[7:0];
    if (sel == 2'd1) begin
      b = w[15:8];
    end else if (sel == 2'd2) begin
      b = w[23:16];
    end
    return b;
  endfunction : pick_byte

  function automatic logic is_read_clear(input logic [6:0] a);
    return (a == msb_pkg::IADR_RD_CLR_WH)   ||
           (a == msb_pkg::IADR_RD_CLR_VARH) ||
           (a == msb_pkg::IADR_RD_CLR_VAH)  ||
           (a == msb_pkg::IADR_RD_CLR_IPK)  ||
           (a == msb_pkg::IADR_RD_CLR_VPK);
  endfunction : is_read_clear

  logic [CW-1:0]       tick_cnt_reg;
  logic [7:0]          ptr_reg;
  logic [23:0]         data_reg;
  logic [23:0]         vrms_lat_reg;
  logic [23:0]         irms_lat_reg;
  logic [23:0]         wav1_lat_reg;
  logic [23:0]         wav2_lat_reg;
  msb_pkg::msb_state_t state_reg;
  logic                ptr_wr;
  logic                capture;

  assign ptr_wr  = sfr_wr && (sfr_addr == msb_pkg::SFR_PTR);
  assign capture = (state_reg == msb_pkg::MSB_FETCH) && meter_tick;

  // Metering clock enable: one pulse every TICK_CYC system cycles.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_reg <= '0;
      meter_tick   <= 1'b0;
    end else if (tick_cnt_reg == CW'(TICK_CYC - 1)) begin
      tick_cnt_reg <= '0;
      meter_tick   <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + CW'(1);
      meter_tick   <= 1'b0;
    end
  end

  // Pointer register; writing it while idle starts a transfer.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_reg <= msb_pkg::BYTE_ZERO;
    end else if (ptr_wr) begin
      ptr_reg <= sfr_wdata;
    end
  end

  // Transfer sequencer, aligned to metering ticks.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= msb_pkg::MSB_IDLE;
      xfer_busy <= 1'b0;
    end else begin
      unique case (state_reg)
        msb_pkg::MSB_IDLE: begin
          if (ptr_wr) begin
            state_reg <= msb_pkg::MSB_ISSUE;
            xfer_busy <= 1'b1;
          end
        end
        msb_pkg::MSB_ISSUE: begin
          if (meter_tick) begin
            if (ptr_reg[msb_pkg::PTR_DIR_BIT]) begin
              state_reg <= msb_pkg::MSB_IDLE;
              xfer_busy <= 1'b0;
            end else begin
              state_reg <= msb_pkg::MSB_FETCH;
            end
          end
        end
        msb_pkg::MSB_FETCH: begin
          if (meter_tick) begin
            state_reg <= msb_pkg::MSB_IDLE;
            xfer_busy <= 1'b0;
          end
        end
        default: begin
          state_reg <= msb_pkg::MSB_IDLE;
          xfer_busy <= 1'b0;
        end
      endcase
    end
  end

  // Request toward the metering register file, one system cycle wide.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mreq <= '0;
    end else begin
      mreq.wr_stb   <= 1'b0;
      mreq.rd_stb   <= 1'b0;
      mreq.rd_clear <= 1'b0;
      // The target is selected on the pointer write, so the width flag from
      // the register file has settled by the time the request issues.
      if ((state_reg == msb_pkg::MSB_IDLE) && ptr_wr) begin
        mreq.addr <= sfr_wdata[msb_pkg::PTR_ADR_MSB:0];
      end
      if ((state_reg == msb_pkg::MSB_ISSUE) && meter_tick) begin
        mreq.addr <= ptr_reg[msb_pkg::PTR_ADR_MSB:0];
        if (ptr_reg[msb_pkg::PTR_DIR_BIT]) begin
          mreq.wr_stb <= 1'b1;
          if (mreg_one_byte) begin
            mreq.wdata <= {msb_pkg::BYTE_ZERO, msb_pkg::BYTE_ZERO,
                           data_reg[7:0]};
          end else begin
            mreq.wdata <= data_reg;
          end
        end else begin
          mreq.rd_stb   <= 1'b1;
          mreq.rd_clear <=
            is_read_clear(ptr_reg[msb_pkg::PTR_ADR_MSB:0]);
        end
      end
    end
  end

  // Data bytes: software writes, or the result of an internal read.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_reg <= msb_pkg::WORD_ZERO;
    end else if (capture) begin
      if (mreg_one_byte) begin
        data_reg <= {16'h0000, mreg_rdata[7:0]};
      end else begin
        data_reg <= mreg_rdata;
      end
    end else if (sfr_wr) begin
      if (sfr_addr == msb_pkg::SFR_DAT_L) begin
        data_reg[7:0] <= sfr_wdata;
      end
      if (sfr_addr == msb_pkg::SFR_DAT_M) begin
        data_reg[15:8] <= sfr_wdata;
      end
      if (sfr_addr == msb_pkg::SFR_DAT_H) begin
        data_reg[23:16] <= sfr_wdata;
      end
    end
  end

  // Interrupt enable bytes.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_enable <= msb_pkg::WORD_ZERO;
    end else if (sfr_wr) begin
      if (sfr_addr == msb_pkg::SFR_IEN_L) begin
        irq_enable[7:0] <= sfr_wdata;
      end
      if (sfr_addr == msb_pkg::SFR_IEN_M) begin
        irq_enable[15:8] <= sfr_wdata;
      end
      if (sfr_addr == msb_pkg::SFR_IEN_H) begin
        irq_enable[23:16] <= sfr_wdata;
      end
    end
  end

  // Interrupt status: a write stores the byte, but an event in the same
  // cycle still sets its bit so it is never lost.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_status <= msb_pkg::WORD_ZERO;
    end else begin
      logic [23:0] st;
      st = irq_status;
      if (sfr_wr && (sfr_addr == msb_pkg::SFR_IST_L)) begin
        st[7:0] = sfr_wdata;
      end
      if (sfr_wr && (sfr_addr == msb_pkg::SFR_IST_M)) begin
        st[15:8] = sfr_wdata;
      end
      if (sfr_wr && (sfr_addr == msb_pkg::SFR_IST_H)) begin
        st[23:16] = sfr_wdata;
      end
      irq_status <= st | irq_event;
    end
  end

  // Three-byte results are captured whole when the high byte is read.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vrms_lat_reg <= msb_pkg::WORD_ZERO;
      irms_lat_reg <= msb_pkg::WORD_ZERO;
      wav1_lat_reg <= msb_pkg::WORD_ZERO;
      wav2_lat_reg <= msb_pkg::WORD_ZERO;
    end else if (sfr_rd) begin
      if (sfr_addr == msb_pkg::SFR_VRMS_H) begin
        vrms_lat_reg <= direct_in.vrms;
      end
      if (sfr_addr == msb_pkg::SFR_IRMS_H) begin
        irms_lat_reg <= direct_in.irms;
      end
      if (sfr_addr == msb_pkg::SFR_WAV1_H) begin
        wav1_lat_reg <= direct_in.wav1;
      end
      if (sfr_addr == msb_pkg::SFR_WAV2_H) begin
        wav2_lat_reg <= direct_in.wav2;
      end
    end
  end

  // Read data, registered in the cycle of the read strobe.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= msb_pkg::BYTE_ZERO;
      sfr_hit   <= 1'b0;
    end else if (sfr_rd) begin
      sfr_hit <= 1'b1;
      unique case (sfr_addr)
        msb_pkg::SFR_PTR:    sfr_rdata <= ptr_reg;
        msb_pkg::SFR_DAT_L:  sfr_rdata <= pick_byte(data_reg, 2'd0);
        msb_pkg::SFR_DAT_M:  sfr_rdata <= pick_byte(data_reg, 2'd1);
        msb_pkg::SFR_DAT_H:  sfr_rdata <= pick_byte(data_reg, 2'd2);
        // Rms bytes have no write path.
        // Low and middle bytes give the held sample.
        msb_pkg::SFR_VRMS_L: sfr_rdata <= pick_byte(vrms_lat_reg, 2'd0);
        msb_pkg::SFR_VRMS_M: sfr_rdata <= pick_byte(vrms_lat_reg, 2'd1);
        msb_pkg::SFR_VRMS_H: sfr_rdata <= pick_byte(direct_in.vrms, 2'd2);
        msb_pkg::SFR_IRMS_L: sfr_rdata <= pick_byte(irms_lat_reg, 2'd0);
        msb_pkg::SFR_IRMS_M: sfr_rdata <= pick_byte(irms_lat_reg, 2'd1);
        msb_pkg::SFR_IRMS_H: sfr_rdata <= pick_byte(direct_in.irms, 2'd2);
        // Interrupt bytes are read live, byte by byte.
        msb_pkg::SFR_IEN_L:  sfr_rdata <= pick_byte(irq_enable, 2'd0);
        msb_pkg::SFR_IEN_M:  sfr_rdata <= pick_byte(irq_enable, 2'd1);
        msb_pkg::SFR_IEN_H:  sfr_rdata <= pick_byte(irq_enable, 2'd2);
        msb_pkg::SFR_IST_L:  sfr_rdata <= pick_byte(irq_status, 2'd0);
        msb_pkg::SFR_IST_M:  sfr_rdata <= pick_byte(irq_status, 2'd1);
        msb_pkg::SFR_IST_H:  sfr_rdata <= pick_byte(irq_status, 2'd2);
        // Waveform bytes have no write path.
        msb_pkg::SFR_WAV1_L: sfr_rdata <= pick_byte(wav1_lat_reg, 2'd0);
        msb_pkg::SFR_WAV1_M: sfr_rdata <= pick_byte(wav1_lat_reg, 2'd1);
        msb_pkg::SFR_WAV1_H: sfr_rdata <= pick_byte(direct_in.wav1, 2'd2);
        msb_pkg::SFR_WAV2_L: sfr_rdata <= pick_byte(wav2_lat_reg, 2'd0);
        msb_pkg::SFR_WAV2_M: sfr_rdata <= pick_byte(wav2_lat_reg, 2'd1);
        msb_pkg::SFR_WAV2_H: sfr_rdata <= pick_byte(direct_in.wav2, 2'd2);
        default: begin
          sfr_rdata <= msb_pkg::BYTE_ZERO;
          sfr_hit   <= 1'b0;
        end
      endcase
    end else begin
      sfr_hit <= 1'b0;
    end
  end
  // Data bytes are only valid once xfer_busy falls.

endmodule : msb_bridge

//--- bench/msb_bridge_chk.sv
/* Port checker for the metering SFR bridge.
   Assumes it is bound to msb_bridge with the same TICK_CYC. */
module msb_bridge_chk #(
  parameter int TICK_CYC = msb_pkg::MTICK_CYC
) (
  input wire logic                 clk,           // Clock.
  input wire logic                 rst,           // Reset.
  input wire logic [7:0]           sfr_addr,      // Address.
  input wire logic                 sfr_wr,        // Write.
  input wire logic                 sfr_rd,        // Read.
  input wire logic [7:0]           sfr_wdata,     // Write data.
  input wire logic [7:0]           sfr_rdata,     // Read data.
  input wire logic                 sfr_hit,       // Hit.
  input wire msb_pkg::msb_direct_t direct_in,     // Results.
  input wire logic [23:0]          irq_event,     // Events.
  input wire logic [23:0]          irq_enable,    // Enables.
  input wire logic [23:0]          irq_status,    // Status.
  input wire msb_pkg::msb_mreq_t   mreq,          // Request.
  input wire logic [23:0]          mreg_rdata,    // Answer.
  input wire logic                 mreg_one_byte, // Narrow reg.
  input wire logic                 meter_tick,    // Tick.
  input wire logic                 xfer_busy      // Busy.
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BUSY_MAX = 2 * TICK_CYC + 1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_tick_period: assert property (
    meter_tick |-> ##TICK_CYC meter_tick) else $error("tick period wrong");
  a_strobe_tick: assert property (
    (mreq.wr_stb || mreq.rd_stb) |-> $past(meter_tick))
    else $error("strobe not after tick");
  a_start_busy: assert property (
    sfr_wr && sfr_addr == msb_pkg::SFR_PTR && !xfer_busy |=> xfer_busy)
    else $error("pointer write did not start");
  a_busy_bound: assert property (
    $rose(xfer_busy) |-> ##[1:BUSY_MAX] !xfer_busy)
    else $error("transfer too long");
  a_write_done: assert property (
    mreq.wr_stb |-> !xfer_busy && $past(xfer_busy))
    else $error("write strobe and busy disagree");
  a_narrow_write: assert property (
    mreq.wr_stb && mreg_one_byte |-> mreq.wdata[23:8] == 16'h0000)
    else $error("narrow write carries upper bytes");
  a_strobe_pulse: assert property (
    mreq.rd_stb |=> !mreq.rd_stb && !mreq.wr_stb)
    else $error("read strobe too long");
  a_read_clear: assert property (
    mreq.rd_stb |-> mreq.rd_clear ==
      (mreq.addr inside {7'h02, 7'h05, 7'h08, 7'h18, 7'h1A}))
    else $error("read clear flag wrong");
  a_high_latch: assert property (
    sfr_rd && sfr_addr == msb_pkg::SFR_VRMS_H |=>
      sfr_hit && sfr_rdata == $past(direct_in.vrms[23:16]))
    else $error("high byte not live");
  a_hit_cause: assert property (
    sfr_hit |-> $past(sfr_rd)) else $error("hit without read");
  a_irq_set: assert property (
    |irq_event |=> (irq_status & $past(irq_event)) == $past(irq_event))
    else $error("event not held in status");
  a_enable_write: assert property (
    sfr_wr && sfr_addr == msb_pkg::SFR_IEN_M |=>
      irq_enable[15:8] == $past(sfr_wdata))
    else $error("enable byte not written");

  c_write: cover property (mreq.wr_stb);
  c_clear: cover property (mreq.rd_stb && mreq.rd_clear);
  c_hit: cover property (sfr_hit);
endmodule : msb_bridge_chk

bind msb_bridge msb_bridge_chk #(.TICK_CYC(TICK_CYC)) u_chk (.clk, .rst,
  .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_hit, .direct_in,
  .irq_event, .irq_enable, .irq_status, .mreq, .mreg_rdata, .mreg_one_byte,
  .meter_tick, .xfer_busy);

//--- bench/msb_mreg_model.sv
/* Behavioural metering register file behind the bridge.
   Assumes one request at a time and answers by the next tick. */
module msb_mreg_model (
  input  wire logic               clk,          // Clock.
  input  wire logic               rst,          // Reset.
  input  wire msb_pkg::msb_mreq_t mreq,         // Request.
  input  wire logic               meter_tick,   // Tick.
  output logic [23:0]             mreg_rdata,   // Answer.
  output logic                    mreg_one_byte // Narrow reg.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] mem_reg [128];
  logic [23:0] hold_reg;
  logic        valid_reg;

  assign mreg_one_byte = mreq.addr inside {[7'h0B:7'h10], 7'h13};
  // Outside the answer window the data is inverted so stale use shows.
  assign mreg_rdata = valid_reg ? hold_reg : ~hold_reg;

  always_ff @(posedge clk) begin
    if (mreq.wr_stb) begin
      // The word is stored as sent; zeroing narrow writes is the bridge's.
      mem_reg[mreq.addr] <= mreq.wdata;
    end
    if (mreq.rd_stb && mreq.rd_clear) begin
      mem_reg[mreq.addr] <= 24'h00_0000;
    end
  end

  // Narrow registers answer junk above their low byte.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_reg  <= 24'h00_0000;
      valid_reg <= 1'b0;
    end else if (mreq.rd_stb) begin
      hold_reg  <= mreg_one_byte ? {16'hA55A, mem_reg[mreq.addr][7:0]}
                                 : mem_reg[mreq.addr];
      valid_reg <= 1'b1;
    end else if (meter_tick) begin
      valid_reg <= 1'b0;
    end
  end
endmodule : msb_mreg_model

//--- bench/tb_top.sv
/* Self-checking bench for the metering SFR bridge.
   Assumes a shortened metering tick so transfers stay brief. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic       wr;
    logic [7:0] a;
    logic [7:0] d;
  } msb_row_t;
  logic clk, rst, sfr_wr, sfr_rd, sfr_hit, mreg_one_byte, meter_tick;
  logic xfer_busy;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [23:0] irq_event, irq_enable, irq_status, mreg_rdata;
  msb_pkg::msb_direct_t direct_in;
  msb_pkg::msb_mreq_t   mreq;
  int n_mismatch = 0;
  int check_count = 0;
  logic [7:0] lo_adr [4] = '{8'hD1, 8'hD4, 8'hE2, 8'hE5};
  msb_row_t rows [19] = '{'{1, 8'h92, 8'hA5}, '{1, 8'h93, 8'h5A},
    '{1, 8'h94, 8'h3C}, '{0, 8'h92, 8'hA5}, '{0, 8'h93, 8'h5A},
    '{0, 8'h94, 8'h3C}, '{1, 8'hD9, 8'h11}, '{1, 8'hDA, 8'h22},
    '{1, 8'hDB, 8'h33}, '{0, 8'hD9, 8'h11}, '{0, 8'hDA, 8'h22},
    '{0, 8'hDB, 8'h33}, '{1, 8'hDC, 8'h0F}, '{0, 8'hDC, 8'h0F},
    '{0, 8'hE4, 8'h00}, '{0, 8'hE2, 8'h00}, '{1, 8'hD3, 8'hFF},
    '{0, 8'hD3, 8'h00}, '{0, 8'h90, 8'h00}};

  msb_bridge #(.TICK_CYC(4)) dut (.clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd,
    .sfr_wdata, .sfr_rdata, .sfr_hit, .direct_in, .irq_event, .irq_enable,
    .irq_status, .mreq, .mreg_rdata, .mreg_one_byte, .meter_tick, .xfer_busy);
  msb_mreg_model u_mreg (.clk, .rst, .mreq, .meter_tick, .mreg_rdata,
    .mreg_one_byte);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [23:0] e, g);
    check_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      n_mismatch++;
    end
  endtask : chk

  task automatic wr8(input logic [7:0] a, d);
    @(posedge clk);
    sfr_wr    <= 1'b1;
    sfr_addr  <= a;
    sfr_wdata <= d;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask : wr8

  task automatic rd8(input logic [7:0] a, e);
    logic hit_e;
    hit_e = a inside {[8'h91:8'h94], [8'hD1:8'hD6], [8'hD9:8'hDE],
                      [8'hE2:8'hE7]};
    @(posedge clk);
    sfr_rd   <= 1'b1;
    sfr_addr <= a;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1;
    chk($sformatf("sfr %h", a), {16'h0000, e}, {16'h0000, sfr_rdata});
    chk("sfr_hit", {23'h0, hit_e}, {23'h0, sfr_hit});
  endtask : rd8

  // Pointer write, then wait for the transfer plus a software margin.
  task automatic xfer(input logic [7:0] p);
    wr8(msb_pkg::SFR_PTR, p);
    #1;
    for (int k = 0; k < 40 && xfer_busy !== 1'b0; k++) begin
      @(posedge clk);
      #1;
    end
    chk("xfer_busy", 24'h00_0000, {23'h0, xfer_busy});
    repeat (2) @(posedge clk);
  endtask : xfer

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    rst = 1'b1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    irq_event = 24'h00_0000;
    direct_in = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("irq_enable", 24'h00_0000, irq_enable);
    chk("irq_status", 24'h00_0000, irq_status);
    foreach (rows[i]) begin
      if (rows[i].wr) wr8(rows[i].a, rows[i].d);
      else rd8(rows[i].a, rows[i].d);
    end
    @(posedge clk);
    direct_in <= {24'h111213, 24'h212223, 24'h313233, 24'h414243};
    for (int i = 0; i < 4; i++) begin
      rd8(lo_adr[i] + 8'h02, 8'(8'h11 + 16 * i));
    end
    @(posedge clk);
    direct_in <= '1;
    for (int i = 0; i < 4; i++) begin
      rd8(lo_adr[i], 8'(8'h13 + 16 * i));
      rd8(lo_adr[i] + 8'h01, 8'(8'h12 + 16 * i));
      rd8(lo_adr[i] + 8'h02, 8'hFF);
    end
    wr8(msb_pkg::SFR_DAT_L, 8'h01);
    wr8(msb_pkg::SFR_DAT_M, 8'h02);
    wr8(msb_pkg::SFR_DAT_H, 8'h03);
    xfer(8'h94);
    wr8(msb_pkg::SFR_DAT_M, 8'hEE);
    xfer(8'h14);
    rd8(msb_pkg::SFR_DAT_L, 8'h01);
    rd8(msb_pkg::SFR_DAT_M, 8'h02);
    rd8(msb_pkg::SFR_DAT_H, 8'h03);
    xfer(8'h8B);
    xfer(8'h0B);
    rd8(msb_pkg::SFR_DAT_L, 8'h01);
    rd8(msb_pkg::SFR_DAT_M, 8'h00);
    rd8(msb_pkg::SFR_DAT_H, 8'h00);
    wr8(msb_pkg::SFR_DAT_H, 8'h0A);
    xfer(8'h82);
    xfer(8'h02);
    rd8(msb_pkg::SFR_DAT_H, 8'h0A);
    xfer(8'h02);
    rd8(msb_pkg::SFR_DAT_H, 8'h00);
    @(posedge clk);
    irq_event <= 24'h80_0100;
    @(posedge clk);
    irq_event <= 24'h00_0000;
    rd8(msb_pkg::SFR_IST_H, 8'h80);
    rd8(msb_pkg::SFR_IST_M, 8'h01);
    wr8(msb_pkg::SFR_IST_H, 8'h00);
    rd8(msb_pkg::SFR_IST_H, 8'h00);
    // A reset in mid-run must clear what earlier scenarios left behind.
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("irq_enable rst", 24'h00_0000, irq_enable);
    chk("xfer_busy rst", 24'h00_0000, {23'h0, xfer_busy});
    rd8(msb_pkg::SFR_DAT_H, 8'h00);
    give_verdict();
  end
endmodule : tb_top
